/* core/regulator_settings_defs.svh */
`ifndef REGULATOR_SETTINGS_DEFS_SVH
`define REGULATOR_SETTINGS_DEFS_SVH

// ****************************************************************
// Register offsets.
// ****************************************************************
`define OFS_RAIL1        8'h01
`define OFS_RAIL2        8'h02
`define OFS_RAIL3        8'h03
`define OFS_RAIL4        8'h04
`define OFS_RAIL5        8'h05
`define OFS_BUCK_FIRST   8'h06
`define OFS_BUCK_SECOND  8'h07
`define OFS_ENABLE       8'h08

// ****************************************************************
// Reset values.
// ****************************************************************
`define RST_RAIL1        8'h39
`define RST_RAIL2        8'h79
`define RST_RAIL3        8'h8c
`define RST_RAIL4        8'hbe
`define RST_RAIL5        8'hd1
`define RST_BUCK_FIRST   8'h15
`define RST_BUCK_SECOND  8'h13
`define RST_ENABLE       8'h80

// ****************************************************************
// Field positions and writable masks.
// ****************************************************************
`define DELAY_MSB        7
`define DELAY_LSB        5
`define VOLT_MSB         4
`define VOLT_LSB         0
`define FORCED_PWM_BIT   5
`define SELECT_BIT       7
`define BUCK_EN_BIT      5
`define MASK_FULL        8'hff
`define MASK_BUCK_SECOND 8'h3f
`define MASK_ENABLE      8'hbf

// ****************************************************************
// Timing.
// ****************************************************************
`define TICK_US          128
`define CLK_MHZ          50
`define TICK_LAST        4'h8

`endif

/* core/regulator_settings_pkg.sv */
package regulator_settings_pkg;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_COUNT = 2'b01,
    SEQ_DONE  = 2'b10
  } seq_state_e;

  typedef logic [7:0] reg_byte_t;

endpackage

/* core/regulator_settings_bank.sv */
`timescale 1ns/1ps
`default_nettype none
`include "regulator_settings_defs.svh"

module regulator_settings_bank
  import regulator_settings_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_US * `CLK_MHZ
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       hw_enable_pin,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  output var  logic       reg_rvalid,
  output var  logic [4:0] rail_on,
  output var  logic [44:0] rail_level_10mv,
  output var  logic       buck_on,
  output var  logic [7:0] buck_level_10mv,
  output var  logic       buck_forced_pwm,
  output var  logic       sequence_done
);

  // ****************************************************************
  // Register file.
  // ****************************************************************
  localparam int NREG = 9;

  reg_byte_t  regs [NREG];
  reg_byte_t  reset_val [NREG];
  reg_byte_t  write_mask [NREG];
  logic [3:0] reg_index;
  logic       reg_hit;

  assign reset_val[0] = 8'h00;
  assign reset_val[1] = `RST_RAIL1;
  assign reset_val[2] = `RST_RAIL2;
  assign reset_val[3] = `RST_RAIL3;
  assign reset_val[4] = `RST_RAIL4;
  assign reset_val[5] = `RST_RAIL5;
  assign reset_val[6] = `RST_BUCK_FIRST;
  assign reset_val[7] = `RST_BUCK_SECOND;
  assign reset_val[8] = `RST_ENABLE;

  // Offset zero holds a register outside this block, so nothing is writable there.
  assign write_mask[0] = 8'h00;
  assign write_mask[1] = `MASK_FULL;
  assign write_mask[2] = `MASK_FULL;
  assign write_mask[3] = `MASK_FULL;
  assign write_mask[4] = `MASK_FULL;
  assign write_mask[5] = `MASK_FULL;
  assign write_mask[6] = `MASK_FULL;
  assign write_mask[7] = `MASK_BUCK_SECOND;
  assign write_mask[8] = `MASK_ENABLE;

  assign reg_hit   = (reg_addr >= `OFS_RAIL1) && (reg_addr <= `OFS_ENABLE);
  assign reg_index = reg_addr[3:0];

  // Reset constants are the printed register values, not the buck table defaults.
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          case (gi)
            1: regs[gi] <= `RST_RAIL1;
            2: regs[gi] <= `RST_RAIL2;
            3: regs[gi] <= `RST_RAIL3;
            4: regs[gi] <= `RST_RAIL4;
            5: regs[gi] <= `RST_RAIL5;
            6: regs[gi] <= `RST_BUCK_FIRST;
            7: regs[gi] <= `RST_BUCK_SECOND;
            8: regs[gi] <= `RST_ENABLE;
            default: regs[gi] <= 8'h00;
          endcase
        end else if (reg_wr && reg_hit && (reg_index == 4'(gi))) begin
          regs[gi] <= reg_wdata & write_mask[gi];
        end
      end
    end
  endgenerate

  // Unmapped offsets read as zero so a stray pointer never returns stale data.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= reg_hit ? regs[reg_index] : 8'h00;
      end
    end
  end

  // ****************************************************************
  // Startup tick and sequencer.
  // ****************************************************************
  logic [15:0] tick_div;
  logic        tick;
  logic [3:0]  tick_count;
  seq_state_e  seq_state;

  assign tick = (tick_div == 16'(TICK_CYCLES - 1));

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_div <= 16'h0000;
    end else if (!hw_enable_pin || tick) begin
      tick_div <= 16'h0000;
    end else begin
      tick_div <= tick_div + 16'h0001;
    end
  end

  // The count saturates once the longest delay code has expired.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      seq_state  <= SEQ_IDLE;
      tick_count <= 4'h0;
    end else begin
      case (seq_state)
        SEQ_IDLE: begin
          tick_count <= 4'h0;
          if (hw_enable_pin) begin
            seq_state <= SEQ_COUNT;
          end
        end
        SEQ_COUNT: begin
          if (!hw_enable_pin) begin
            seq_state  <= SEQ_IDLE;
            tick_count <= 4'h0;
          end else if (tick) begin
            tick_count <= tick_count + 4'h1;
            if (tick_count + 4'h1 == `TICK_LAST) begin
              seq_state <= SEQ_DONE;
            end
          end
        end
        SEQ_DONE: begin
          if (!hw_enable_pin) begin
            seq_state  <= SEQ_IDLE;
            tick_count <= 4'h0;
          end
        end
        default: begin
          seq_state  <= SEQ_IDLE;
          tick_count <= 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sequence_done <= 1'b1;
    end else begin
      sequence_done <= (seq_state != SEQ_COUNT);
    end
  end

  // ****************************************************************
  // Rail start and levels.
  // ****************************************************************
  function automatic logic [8:0] high_table(input logic [4:0] c);
    logic [8:0] v;
    v = 9'd170;
    if (c <= 5'd10)      v = 9'd170;
    else if (c == 5'd11) v = 9'd175;
    else if (c == 5'd12) v = 9'd180;
    else if (c == 5'd13) v = 9'd185;
    else if (c == 5'd14) v = 9'd190;
    else if (c == 5'd15) v = 9'd200;
    else if (c <= 5'd21) v = 9'd210 + 9'(10 * (c - 5'd16));
    else if (c <= 5'd29) v = 9'd265 + 9'(5 * (c - 5'd22));
    else if (c == 5'd30) v = 9'd310;
    else                 v = 9'd330;
    return v;
  endfunction

  function automatic logic [8:0] low_table(input logic [4:0] c);
    logic [8:0] v;
    v = 9'd120;
    if (c <= 5'd5)       v = 9'd120;
    else if (c <= 5'd17) v = 9'd125 + 9'(5 * (c - 5'd6));
    else if (c == 5'd18) v = 9'd185;
    else if (c == 5'd19) v = 9'd190;
    else if (c <= 5'd25) v = 9'd200 + 9'(10 * (c - 5'd20));
    else                 v = 9'd260 + 9'(5 * (c - 5'd26));
    return v;
  endfunction

  function automatic logic [7:0] buck_table(input logic [4:0] c);
    logic [7:0] v;
    v = 8'd80;
    if (c > 5'd1) v = 8'd80 + 8'(5 * (c - 5'd1));
    return v;
  endfunction

  // Equal codes on neighbouring rails start both in the same cycle; the hardware allows it.
  generate
    for (gi = 0; gi < 5; gi++) begin : g_rail
      logic [2:0] delay_code;
      logic [4:0] volt_code;
      assign delay_code = regs[gi + 1][`DELAY_MSB:`DELAY_LSB];
      assign volt_code  = regs[gi + 1][`VOLT_MSB:`VOLT_LSB];
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          rail_on[gi]                  <= 1'b0;
          rail_level_10mv[gi*9 +: 9]   <= 9'd0;
        end else begin
          rail_on[gi] <= hw_enable_pin && regs[8][gi] &&
                         (tick_count > {1'b0, delay_code});
          rail_level_10mv[gi*9 +: 9] <= (gi < 3) ? high_table(volt_code)
                                                 : low_table(volt_code);
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      buck_on         <= 1'b0;
      buck_level_10mv <= 8'd0;
      buck_forced_pwm <= 1'b0;
    end else begin
      buck_on <= hw_enable_pin && regs[8][`BUCK_EN_BIT] &&
                 (tick_count > {1'b0, regs[6][`DELAY_MSB:`DELAY_LSB]});
      buck_level_10mv <= regs[8][`SELECT_BIT]
                         ? buck_table(regs[6][`VOLT_MSB:`VOLT_LSB])
                         : buck_table(regs[7][`VOLT_MSB:`VOLT_LSB]);
      buck_forced_pwm <= regs[7][`FORCED_PWM_BIT];
    end
  end

endmodule // regulator_settings_bank
`default_nettype wire

/* bench/regulator_settings_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checks.
// ****
module regulator_settings_checker #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        hw_enable_pin,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic [4:0]  rail_on,
  input wire logic [44:0] rail_level_10mv,
  input wire logic        buck_on,
  input wire logic [7:0]  buck_level_10mv,
  input wire logic        buck_forced_pwm,
  input wire logic        sequence_done
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  read_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  hole_zero_a: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  spare_zero_a: assert property (reg_rd && reg_addr == 8'h07 |=> reg_rdata[7:6] == 2'h0)
    else $error("spare bits not zero");
  pwm_follow_a: assert property (reg_wr && reg_addr == 8'h07 |-> ##2 buck_forced_pwm == $past(reg_wdata[5], 2))
    else $error("mode bit not followed");
  quiet_start_a: assert property ($rose(hw_enable_pin) |-> ##1 (rail_on == 5'h00 && !buck_on) [*3])
    else $error("rail started too early");
  off_when_low_a: assert property (!hw_enable_pin ##1 !hw_enable_pin |-> rail_on == 5'h00 && !buck_on)
    else $error("rail on with pin low");
  busy_on_rise_a: assert property ($rose(hw_enable_pin) |-> ##[1:3] !sequence_done)
    else $error("sequence not started");
  high_table_a: assert property ($past(rst_b) |-> rail_level_10mv[8:0] inside {[9'h0aa:9'h14a]})
    else $error("rail1 level out of table");
  low_table_a: assert property ($past(rst_b) |-> rail_level_10mv[44:36] inside {[9'h078:9'h11d]})
    else $error("rail5 level out of table");
  buck_table_a: assert property ($past(rst_b) |-> buck_level_10mv inside {[8'h50:8'he6]})
    else $error("buck level out of table");
endmodule // regulator_settings_checker
`default_nettype wire

/* bench/reg_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Host side of the byte port.
// ****
module reg_host_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    // Released data is inverted so a late sample cannot pass by luck.
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    d = 8'hxx;
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    // The answer stands for one cycle only, right after the edge that takes the strobe.
    for (int i = 0; i < 4; i++) begin
      #1;
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        break;
      end
      @(posedge ref_clk);
    end
  endtask
endmodule // reg_host_model
`default_nettype wire

/* bench/regulator_settings_bank_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "regulator_settings_defs.svh"
// ****
// Bench top.
// ****
module regulator_settings_bank_tb import regulator_settings_pkg::*;;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        hw_enable_pin = 1'b0;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, buck_level_10mv, d;
  logic        reg_wr, reg_rd, reg_rvalid, buck_on, buck_forced_pwm, sequence_done;
  logic [4:0]  rail_on;
  logic [5:0]  on;
  logic [44:0] rail_level_10mv;
  int          t [6] = '{default: 0};
  int          failures = 0;
  int          n_compared = 0;
  reg_byte_t   rst_tab [9] = '{8'h00, `RST_RAIL1, `RST_RAIL2, `RST_RAIL3, `RST_RAIL4,
                               `RST_RAIL5, `RST_BUCK_FIRST, `RST_BUCK_SECOND, `RST_ENABLE};
  regulator_settings_bank #(.TICK_CYCLES(4)) regulator_settings_bank_i (.ref_clk, .rst_b, .hw_enable_pin,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .rail_on, .rail_level_10mv,
    .buck_on, .buck_level_10mv, .buck_forced_pwm, .sequence_done);
  reg_host_model reg_host_model_i (.ref_clk, .reg_rdata, .reg_rvalid, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic lvl(logic [7:0] a, logic [7:0] v, logic [1:0] sel, logic [8:0] e);
    reg_host_model_i.wr(a, v);
    repeat (3) @(posedge ref_clk);
    #1;
    check("level", sel == 2'h0 ? rail_level_10mv[8:0] : sel == 2'h1 ? rail_level_10mv[44:36] : buck_level_10mv, e);
  endtask
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      reg_host_model_i.rd(i[7:0], d);
      check("reset", d, rst_tab[i]);
    end
    reg_host_model_i.rd(8'h0c, d);
    check("hole", d, 8'h00);
    check("pwm", buck_forced_pwm, 1'b0);
    reg_host_model_i.wr(8'h07, 8'hff);
    reg_host_model_i.rd(8'h07, d);
    check("buck2", d, 8'h3f);
    check("pwm", buck_forced_pwm, 1'b1);
    reg_host_model_i.wr(8'h06, 8'hff);
    reg_host_model_i.rd(8'h06, d);
    check("buck1", d, 8'hff);
    lvl(8'h01, 8'h0a, 2'h0, 9'h0aa);
    lvl(8'h01, 8'h0b, 2'h0, 9'h0af);
    lvl(8'h01, 8'h1f, 2'h0, 9'h14a);
    lvl(8'h05, 8'h05, 2'h1, 9'h078);
    lvl(8'h05, 8'h06, 2'h1, 9'h07d);
    lvl(8'h05, 8'h10, 2'h1, 9'h0af);
    lvl(8'h05, 8'h1f, 2'h1, 9'h11d);
    lvl(8'h06, 8'h01, 2'h2, 9'h050);
    lvl(8'h06, 8'h1f, 2'h2, 9'h0e6);
    lvl(8'h07, 8'h02, 2'h2, 9'h0e6);
    lvl(8'h08, 8'h00, 2'h2, 9'h055);
    for (int i = 1; i < 6; i++) begin
      reg_host_model_i.wr(i[7:0], {i[2:0] - 3'h1, 5'h10});
    end
    reg_host_model_i.wr(8'h06, 8'he9);
    reg_host_model_i.wr(8'h08, 8'hff);
    reg_host_model_i.rd(8'h08, d);
    check("enable", d, 8'hbf);
    reg_host_model_i.wr(8'h08, 8'haf);
    @(posedge ref_clk);
    hw_enable_pin <= 1'b1;
    for (int c = 0; c < 50; c++) begin
      @(posedge ref_clk);
      #1;
      on = {buck_on, rail_on};
      for (int j = 0; j < 6; j++) begin
        if (on[j] === 1'b1 && t[j] == 0) t[j] = c;
      end
    end
    for (int j = 0; j < 4; j++) begin
      check("start", 16'(t[j] - 4 * j - 4) <= 16'h2, 1'b1);
    end
    check("buck start", 16'(t[5] - 32) <= 16'h2, 1'b1);
    check("rail5 off", 16'(t[4]), 16'h0);
    check("done", sequence_done, 1'b1);
    @(posedge ref_clk);
    hw_enable_pin <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    check("low", {buck_on, rail_on}, 6'h00);
    wrap_up();
  end
endmodule // regulator_settings_bank_tb
bind regulator_settings_bank regulator_settings_checker #(.TICK_CYCLES(TICK_CYCLES)) regulator_settings_checker_i (
  .ref_clk, .rst_b, .hw_enable_pin, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
  .rail_on, .rail_level_10mv, .buck_on, .buck_level_10mv, .buck_forced_pwm, .sequence_done);
`default_nettype wire
